// ### swc_defs.svh
// Offsets, field positions, writable mask and reset pulse length for the switch control register.
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
`define SWC_SWITCH_CONTROL_OFFSET 12'h404
`define SWC_BIT_FUND_RST          0
`define SWC_BIT_HOT_RST           1
`define SWC_BIT_RESET_HOLD        2
`define SWC_BIT_REG_UNLOCK        3
`define SWC_BIT_PWR_BUDGET_UL     4
`define SWC_BIT_LINK_DOWN_HR_DIS  5
`define SWC_BIT_HR_EEPROM_SKIP    6
`define SWC_BIT_RELAXED_ORD_DIS   7
`define SWC_BIT_P2P_DIS           8
`define SWC_BIT_CUT_THROUGH_DIS   14
`define SWC_BIT_LOCK_IGNORE       15
`define SWC_WRITABLE_MASK         32'h0000_C1FC
`define SWC_PB_COUNT              8
`define SWC_RESET_PULSE_CYCLES    4'h8
`endif

// ### swc_pkg.sv
// Types shared by the switch control register files.
package swc_pkg;
	typedef enum logic [1:0]
	{
		SWC_RUN      = 2'b00,
		SWC_FUND_RST = 2'b01,
		SWC_HOT_RST  = 2'b10,
		SWC_HOLD     = 2'b11
	} swc_state_t;
endpackage

// ### swc_rst_seq.sv
// Reset sequencer: turns reset requests into timed reset phases and a hold.
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_rst_seq
(
	// Clock and reset.
	input  wire logic clk_sys_i,
	input  wire logic srst_i,
	// Requests and controls.
	input  wire logic fund_req_i,
	input  wire logic hot_req_i,
	input  wire logic hold_i,
	// Reset phase outputs.
	output logic      fund_active_o,
	output logic      hot_active_o,
	output logic      in_reset_o,
	output logic      held_o
);
	swc_pkg::swc_state_t state_q;
	swc_pkg::swc_state_t state_d;
	logic [3:0]          cnt_q;
	logic                cnt_done;

	// The phase ends once the pulse counter expires.
	assign cnt_done = (cnt_q == `SWC_RESET_PULSE_CYCLES);

	// Fundamental reset takes priority over hot reset; the hold is checked at phase end and while held.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			swc_pkg::SWC_RUN:
				if (fund_req_i)
					state_d = swc_pkg::SWC_FUND_RST;
				else if (hot_req_i)
					state_d = swc_pkg::SWC_HOT_RST;
			swc_pkg::SWC_FUND_RST, swc_pkg::SWC_HOT_RST:
				if (fund_req_i)
					state_d = swc_pkg::SWC_FUND_RST;
				else if (cnt_done)
					state_d = hold_i ? swc_pkg::SWC_HOLD : swc_pkg::SWC_RUN;
			swc_pkg::SWC_HOLD:
				if (fund_req_i)
					state_d = swc_pkg::SWC_FUND_RST;
				else if (!hold_i)
					state_d = swc_pkg::SWC_RUN;
			default:
				state_d = swc_pkg::SWC_RUN;
		endcase
	end

	// State and phase counter.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			state_q <= swc_pkg::SWC_FUND_RST;
			cnt_q   <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= (state_d != state_q || state_q == swc_pkg::SWC_HOLD) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	assign fund_active_o = (state_q == swc_pkg::SWC_FUND_RST);
	assign hot_active_o  = (state_q == swc_pkg::SWC_HOT_RST);
	assign held_o        = (state_q == swc_pkg::SWC_HOLD);
	assign in_reset_o    = (state_q != swc_pkg::SWC_RUN);
endmodule // swc_rst_seq

// ### swc_pb_bank.sv
// Eight sticky power-budget data value words, writable only when unlocked.
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_pb_bank #(parameter int N = `SWC_PB_COUNT)
(
	// Clock.
	input  wire logic        clk_sys_i,
	// Write port.
	input  wire logic        unlock_i,
	input  wire logic        wr_i,
	input  wire logic [2:0]  idx_i,
	input  wire logic [31:0] wdata_i,
	// Read port.
	output logic [31:0]      rdata_o
);
	logic [31:0] mem_q [N];

	// Sticky storage: no reset of any kind touches it.
	always_ff @(posedge clk_sys_i)
	begin
		if (wr_i && unlock_i)
			mem_q[idx_i] <= wdata_i;
	end

	assign rdata_o = mem_q[idx_i];
endmodule // swc_pb_bank

// ### swc_switch_control.sv
// Switch control register with reset triggers, unlocks and routing disables.
// Behaviour
// - Writing one to bit 0 starts fundamental reset; bit reads zero.
// - Writing one to bit 1 starts hot reset; bit reads zero.
// - Reset-hold keeps switch except SMBus in reset; clearing lets operation begin.
// - Reset-hold only matters during a reset operation.
// - EEPROM load error or EEPROM content sets reset-hold, except while the fundamental phase runs, when the halt strap is loaded instead.
// - Register-unlock set lets lock-protected fields be written; clear makes them read-only.
// - Register-unlock resets to zero but is set during every reset operation.
// - Power-budget unlock makes eight data value registers writable.
// - Link-down hot reset disable blocks hot reset from upstream DL_Down.
// - EEPROM-skip bit omits EEPROM step of hot reset sequence.
// - Relaxed-ordering disable forces strict ordering of all transactions.
// - Peer-to-peer disable makes non-upstream downstream requests unsupported.
// - Cut-through disable forces store-and-forward routing between all ports.
// - Lock-ignore discards locking side effects and routes locked TLPs normally.
// - Power-budget writes are ignored while its unlock is clear.
// - Sticky fields survive a hot reset unchanged.
// - Reset-hold reset value comes from the halt strap sampled in fundamental reset.
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_switch_control
(
	// Clock and reset.
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	// Configuration/SMBus register access.
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	output logic [31:0]      reg_rdata_o,
	// Power-budget data value access.
	input  wire logic        pb_wr_i,
	input  wire logic        pb_rd_i,
	input  wire logic [2:0]  pb_idx_i,
	input  wire logic [31:0] pb_wdata_i,
	output logic [31:0]      pb_rdata_o,
	// Pins and events.
	input  wire logic        reset_halt_pin_i,
	input  wire logic        eeprom_err_i,
	input  wire logic        eeprom_set_hold_i,
	input  wire logic        eeprom_done_i,
	input  wire logic        us_dl_down_i,
	input  wire logic        hot_req_other_i,
	// Control hooks toward the switch.
	output logic             fund_reset_o,
	output logic             hot_reset_o,
	output logic             core_reset_o,
	output logic             eeprom_load_en_o,
	output logic             lock_wr_en_o,
	output logic             relaxed_ord_dis_o,
	output logic             p2p_dis_o,
	output logic             cut_through_dis_o,
	output logic             lock_ignore_o
);
	logic        halt_s1_q;
	logic        halt_s2_q;
	logic        dl_s1_q;
	logic        dl_s2_q;
	logic        dl_prev_q;
	logic        reset_hold_q;
	logic        reg_unlock_q;
	logic        pb_unlock_q;
	logic        ld_hr_dis_q;
	logic        hr_ee_skip_q;
	logic        ro_dis_q;
	logic        p2p_dis_q;
	logic        ct_dis_q;
	logic        lock_ign_q;
	logic        fund_req_q;
	logic        hot_req_q;
	logic [31:0] reg_rdata_q;
	logic [31:0] pb_rdata_q;
	logic        fund_reset_q;
	logic        hot_reset_q;
	logic        core_reset_q;
	logic        ee_load_q;
	logic        fund_active;
	logic        hot_active;
	logic        in_reset;
	logic        held;
	logic [31:0] pb_word;
	logic [31:0] ctl_word;

	// Decode of the one register and of its write effects.
	wire         hit       = (reg_addr_i == `SWC_SWITCH_CONTROL_OFFSET);
	wire         wr_hit    = reg_wr_i && hit;
	wire         fund_trig = wr_hit && reg_wdata_i[`SWC_BIT_FUND_RST];
	wire         hot_trig  = wr_hit && reg_wdata_i[`SWC_BIT_HOT_RST];
	wire         dl_fall   = dl_s2_q && !dl_prev_q;
	wire         ld_hot    = dl_fall && !ld_hr_dis_q;
	wire         hot_any   = hot_trig || ld_hot || hot_req_other_i;
	wire         lock_wr   = wr_hit && reg_unlock_q;

	// Triggers read as zero; reserved bits read as zero.
	assign ctl_word = {16'h0000, lock_ign_q, ct_dis_q, 5'h00, p2p_dis_q, ro_dis_q,
		hr_ee_skip_q, ld_hr_dis_q, pb_unlock_q, reg_unlock_q, reset_hold_q, 2'b00};

	// Strap and link-state inputs come from pins, so each is double synchronised.
	always_ff @(posedge clk_sys_i)
	begin
		halt_s1_q <= reset_halt_pin_i;
		halt_s2_q <= halt_s1_q;
		dl_s1_q   <= us_dl_down_i;
		dl_s2_q   <= dl_s1_q;
		dl_prev_q <= dl_s2_q;
	end

	// Reset requests are registered so the sequencer sees clean pulses.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			fund_req_q <= 1'b0;
			hot_req_q  <= 1'b0;
		end
		else
		begin
			fund_req_q <= fund_trig;
			hot_req_q  <= hot_any;
		end
	end

	// Reset-hold: strap at fundamental reset, EEPROM sets it, otherwise written at any time.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			reset_hold_q <= 1'b0;
		else if (fund_active)
			reset_hold_q <= halt_s2_q;
		else if (eeprom_err_i || eeprom_set_hold_i)
			reset_hold_q <= 1'b1;
		else if (wr_hit)
			reset_hold_q <= reg_wdata_i[`SWC_BIT_RESET_HOLD];
	end

	// Register unlock: cleared by srst_i, then forced on in every reset phase.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			reg_unlock_q <= 1'b0;
		else if (fund_active || hot_active)
			reg_unlock_q <= 1'b1;
		else if (wr_hit)
			reg_unlock_q <= reg_wdata_i[`SWC_BIT_REG_UNLOCK];
	end

	// Sticky control bits: only fundamental reset clears them, hot reset never does.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i || fund_active)
		begin
			pb_unlock_q  <= 1'b0;
			ld_hr_dis_q  <= 1'b0;
			hr_ee_skip_q <= 1'b0;
			ro_dis_q     <= 1'b0;
			p2p_dis_q    <= 1'b0;
			ct_dis_q     <= 1'b0;
			lock_ign_q   <= 1'b0;
		end
		else if (wr_hit)
		begin
			if (lock_wr)
				pb_unlock_q <= reg_wdata_i[`SWC_BIT_PWR_BUDGET_UL];
			ld_hr_dis_q  <= reg_wdata_i[`SWC_BIT_LINK_DOWN_HR_DIS];
			hr_ee_skip_q <= reg_wdata_i[`SWC_BIT_HR_EEPROM_SKIP];
			ro_dis_q     <= reg_wdata_i[`SWC_BIT_RELAXED_ORD_DIS];
			p2p_dis_q    <= reg_wdata_i[`SWC_BIT_P2P_DIS];
			ct_dis_q     <= reg_wdata_i[`SWC_BIT_CUT_THROUGH_DIS];
			lock_ign_q   <= reg_wdata_i[`SWC_BIT_LOCK_IGNORE];
		end
	end

	// Reset phases; the hold is sampled when a phase ends and while held, so changes while running are inert.
	swc_rst_seq u_seq
	(
		.clk_sys_i     (clk_sys_i),
		.srst_i        (srst_i),
		.fund_req_i    (fund_req_q),
		.hot_req_i     (hot_req_q),
		.hold_i        (reset_hold_q),
		.fund_active_o (fund_active),
		.hot_active_o  (hot_active),
		.in_reset_o    (in_reset),
		.held_o        (held)
	);

	// Power-budget words, gated by their unlock.
	swc_pb_bank u_pb
	(
		.clk_sys_i (clk_sys_i),
		.unlock_i  (pb_unlock_q),
		.wr_i      (pb_wr_i),
		.idx_i     (pb_idx_i),
		.wdata_i   (pb_wdata_i),
		.rdata_o   (pb_word)
	);

	// Registered outputs; the EEPROM step is dropped from hot reset when skipped.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			reg_rdata_q  <= 32'h0000_0000;
			pb_rdata_q   <= 32'h0000_0000;
			fund_reset_q <= 1'b1;
			hot_reset_q  <= 1'b0;
			core_reset_q <= 1'b1;
			ee_load_q    <= 1'b0;
		end
		else
		begin
			reg_rdata_q  <= (reg_rd_i && hit) ? ctl_word : 32'h0000_0000;
			pb_rdata_q   <= pb_rd_i ? pb_word : 32'h0000_0000;
			fund_reset_q <= fund_active;
			hot_reset_q  <= hot_active;
			core_reset_q <= in_reset || held;
			ee_load_q    <= (fund_active || (hot_active && !hr_ee_skip_q)) && !eeprom_done_i;
		end
	end

	assign reg_rdata_o       = reg_rdata_q;
	assign pb_rdata_o        = pb_rdata_q;
	assign fund_reset_o      = fund_reset_q;
	assign hot_reset_o       = hot_reset_q;
	assign core_reset_o      = core_reset_q;
	assign eeprom_load_en_o  = ee_load_q;
	assign lock_wr_en_o      = reg_unlock_q;
	assign relaxed_ord_dis_o = ro_dis_q;
	assign p2p_dis_o         = p2p_dis_q;
	assign cut_through_dis_o = ct_dis_q;
	assign lock_ignore_o     = lock_ign_q;


	// Launch steps: the trigger write, then the registered request one cycle later.
	sequence s_fund_launch;
		fund_trig ##1 fund_req_q;
	endsequence
	// A hot launch from a running switch with no fundamental request pending.
	sequence s_hot_launch;
		(!in_reset && !fund_req_q && !fund_trig && hot_trig) ##1 hot_req_q;
	endsequence

	// A fundamental-reset trigger write starts a fundamental phase two cycles later.
	a_fund_trigger: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		fund_trig |-> ##2 fund_active) else $error("fund trigger lost");
	// Once the request is registered, the fundamental phase follows on the next edge.
	a_fund_launch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_fund_launch |=> fund_active) else $error("fund launch lost");
	// A hot trigger from a running switch reaches the hot phase when no fundamental request is pending.
	a_hot_launch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_hot_launch |=> hot_active) else $error("hot launch lost");
	// Trigger bits never read back as one.
	a_trig_read_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		reg_rd_i && hit |=> reg_rdata_o[1:0] == 2'b00) else $error("trigger bits read one");
	// Reserved bits are zero on every read.
	a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(reg_rdata_o & ~`SWC_WRITABLE_MASK & 32'hFFFF_FFFC) == 32'h0000_0000)
		else $error("reserved bit set");
	// Holding keeps the core in reset.
	a_hold_core: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		held |=> core_reset_o) else $error("core left reset while held");
	// Outside every phase and hold the core is released on the next edge.
	a_core_release: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!in_reset |=> !core_reset_o) else $error("core kept in reset");
	// Without a request a running switch stays running, whatever the hold bit says.
	a_hold_inert: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!in_reset && !fund_req_q && !hot_req_q |=> !in_reset)
		else $error("hold bit acted outside reset");
	// EEPROM error sets the hold outside fundamental reset.
	a_ee_err_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		eeprom_err_i && !fund_active |=> reset_hold_q) else $error("hold not set");
	// The hold takes the synchronised strap while the fundamental phase runs.
	a_hold_strap: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		fund_active |=> reset_hold_q == $past(halt_s2_q))
		else $error("strap not taken into hold");
	// Unlock comes on during the hot reset phase.
	a_unlock_reset: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		hot_active |=> reg_unlock_q) else $error("unlock not set");
	// The fundamental phase sets the unlock as well.
	a_unlock_fund: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		fund_active |=> reg_unlock_q) else $error("unlock not set by fundamental reset");
	// Locked writes leave the power-budget unlock unchanged.
	a_lock_guard: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_hit && !reg_unlock_q && !fund_active |=> $stable(pb_unlock_q))
		else $error("locked field changed");
	// Link-down with the disable set never raises a hot request.
	a_ld_block: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		dl_fall && ld_hr_dis_q && !hot_trig && !hot_req_other_i |=> !hot_req_q)
		else $error("link-down hot reset not blocked");
	// Link-down with the disable clear raises a hot request.
	a_ld_hot: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		dl_fall && !ld_hr_dis_q |=> hot_req_q) else $error("link-down hot reset lost");
	// EEPROM load is off during a skipped hot reset.
	a_ee_skip: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		hot_active && hr_ee_skip_q |=> !eeprom_load_en_o) else $error("EEPROM not skipped");
	// Without the skip an unfinished EEPROM step is enabled in hot reset.
	a_ee_hot: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		hot_active && !hr_ee_skip_q && !eeprom_done_i |=> eeprom_load_en_o)
		else $error("EEPROM step missing");
	// Hot reset leaves sticky bits alone.
	a_sticky_hot: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		hot_active && !wr_hit |=> $stable(ct_dis_q) && $stable(lock_ign_q))
		else $error("sticky bit changed by hot reset");
endmodule // swc_switch_control

// ### swc_testbench.sv
// Self-checking testbench for the switch control register block.
`timescale 1ns/1ps
`include "swc_defs.svh"
module testbench;
	logic        clk_sys_i, srst_i, reg_wr_i, reg_rd_i, pb_wr_i, pb_rd_i;
	logic [11:0] reg_addr_i;
	logic [31:0] reg_wdata_i, pb_wdata_i, reg_rdata_o, pb_rdata_o;
	logic [2:0]  pb_idx_i;
	logic        reset_halt_pin_i, eeprom_err_i, eeprom_set_hold_i, eeprom_done_i;
	logic        us_dl_down_i, hot_req_other_i, fund_reset_o, hot_reset_o, core_reset_o;
	logic        eeprom_load_en_o, lock_wr_en_o, relaxed_ord_dis_o, p2p_dis_o;
	logic        cut_through_dis_o, lock_ignore_o;
	logic [31:0] sh, rd, w, pbv [8];
	int          errors, total_checks, n;
	localparam logic [11:0] OFF = `SWC_SWITCH_CONTROL_OFFSET;

	// Device under test, every port driven or observed.
	swc_switch_control i_swc_switch_control (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pb_wr_i(pb_wr_i),
		.pb_rd_i(pb_rd_i), .pb_idx_i(pb_idx_i), .pb_wdata_i(pb_wdata_i),
		.pb_rdata_o(pb_rdata_o), .reset_halt_pin_i(reset_halt_pin_i),
		.eeprom_err_i(eeprom_err_i), .eeprom_set_hold_i(eeprom_set_hold_i),
		.eeprom_done_i(eeprom_done_i), .us_dl_down_i(us_dl_down_i),
		.hot_req_other_i(hot_req_other_i), .fund_reset_o(fund_reset_o),
		.hot_reset_o(hot_reset_o), .core_reset_o(core_reset_o),
		.eeprom_load_en_o(eeprom_load_en_o), .lock_wr_en_o(lock_wr_en_o),
		.relaxed_ord_dis_o(relaxed_ord_dis_o), .p2p_dis_o(p2p_dis_o),
		.cut_through_dis_o(cut_through_dis_o), .lock_ignore_o(lock_ignore_o));

	// A 20 MHz clock.
	initial
	begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Register write is one strobe cycle; the next access waits for a fresh edge.
	task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data is registered, so it is sampled just after the taking edge.
	task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	task automatic pb_access(input logic wr, input logic [2:0] i, input logic [31:0] d);
		@(posedge clk_sys_i);
		pb_wr_i    <= wr;
		pb_rd_i    <= ~wr;
		pb_idx_i   <= i;
		pb_wdata_i <= d;
		@(posedge clk_sys_i);
		pb_wr_i <= 1'b0;
		pb_rd_i <= 1'b0;
		#1;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return fund_reset_o;
			1: return hot_reset_o;
			2: return core_reset_o;
			default: return eeprom_load_en_o;
		endcase
	endfunction

	// Bounded wait for a level; running out of time shows as a mismatch.
	task automatic wait_lvl(input int s, input logic v, input int lim);
		n = 0;
		while (pick(s) !== v && n < lim)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check("wait level", v, pick(s));
	endtask

	task automatic stay(input int s, input logic v, input int cyc);
		repeat (cyc)
		begin
			@(posedge clk_sys_i);
			#1;
			if (pick(s) !== v)
				break;
		end
		check("steady level", v, pick(s));
	endtask

	// Expected register after a write: the power-budget unlock only moves while unlocked.
	function automatic logic [31:0] nxt(input logic [31:0] o, input logic [31:0] d);
		nxt = (d & `SWC_WRITABLE_MASK & ~32'h0000_0010) | ((o[3] ? d : o) & 32'h0000_0010);
	endfunction

	task automatic wr_ctl(input logic [31:0] d);
		reg_write(OFF, d);
		sh = nxt(sh, d);
	endtask

	task automatic rd_ctl();
		reg_read(OFF, rd);
		check("switch_control", sh, rd);
	endtask

	// Watchdog sized well above the expected run length.
	initial
	begin
		#(50 * 20000);
		errors++;
		give_verdict();
	end

	initial
	begin
		{reg_wr_i, reg_rd_i, pb_wr_i, pb_rd_i, eeprom_err_i, eeprom_set_hold_i} = '0;
		{eeprom_done_i, us_dl_down_i, hot_req_other_i, reset_halt_pin_i} = '0;
		{reg_addr_i, reg_wdata_i, pb_wdata_i, pb_idx_i} = '0;
		errors = 0;
		total_checks = 0;
		srst_i = 1'b1;
		void'($urandom(14));
		repeat (8) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		wait_lvl(2, 1'b0, 30);
		sh = 32'h0000_0008;
		rd_ctl();
		// Random traffic: trigger bits kept clear, reserved bits set freely.
		for (int i = 0; i < 12; i++)
		begin
			w = $urandom() & ~32'h0000_0003;
			wr_ctl(w);
			rd_ctl();
			check("hooks", {sh[15:14], sh[8:7], sh[3]}, {lock_ignore_o, cut_through_dis_o, p2p_dis_o, relaxed_ord_dis_o, lock_wr_en_o});
			check("core out of reset", 1'b0, core_reset_o);
		end
		// Locked write of the power-budget unlock, then an unlocked one.
		wr_ctl(32'h0000_0000);
		wr_ctl(32'h0000_0010);
		rd_ctl();
		wr_ctl(32'h0000_0008);
		wr_ctl(32'h0000_0018);
		rd_ctl();
		reg_write(12'h408, 32'hFFFF_FFFF);
		rd_ctl();
		reg_read(12'h408, rd);
		check("unmapped", 32'h0, rd);
		// Power-budget words: writable while unlocked, frozen otherwise.
		for (int i = 0; i < 8; i++)
		begin
			pbv[i] = $urandom();
			pb_access(1'b1, 3'(i), pbv[i]);
		end
		wr_ctl(32'h0000_0008);
		for (int i = 0; i < 8; i++)
		begin
			pb_access(1'b1, 3'(i), ~pbv[i]);
			pb_access(1'b0, 3'(i), 32'h0);
			check("pb word", pbv[i], pb_rdata_o);
		end
		// Software hot reset: nine-cycle phase with the EEPROM step inside it.
		wr_ctl(32'h0000_8128);
		reg_write(OFF, sh | 32'h2);
		wait_lvl(1, 1'b1, 6);
		check("eeprom load in hot phase", 1'b1, eeprom_load_en_o);
		n = 0;
		while (hot_reset_o === 1'b1 && n < 20)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check("hot phase length", 32'd9, n);
		check("eeprom load after hot phase", 1'b0, eeprom_load_en_o);
		eeprom_done_i <= 1'b1;
		wait_lvl(2, 1'b0, 40);
		rd_ctl();
		pb_access(1'b0, 3'h5, 32'h0);
		check("pb sticky", pbv[5], pb_rdata_o);
		// Link-down cause is masked, the other cause is not.
		@(posedge clk_sys_i);
		us_dl_down_i <= 1'b1;
		stay(1, 1'b0, 20);
		@(posedge clk_sys_i);
		hot_req_other_i <= 1'b1;
		@(posedge clk_sys_i);
		hot_req_other_i <= 1'b0;
		wait_lvl(1, 1'b1, 8);
		check("eeprom load once done", 1'b0, eeprom_load_en_o);
		wait_lvl(2, 1'b0, 40);
		us_dl_down_i <= 1'b0;
		wr_ctl(sh & ~32'h0000_0020);
		repeat (4) @(posedge clk_sys_i);
		us_dl_down_i <= 1'b1;
		wait_lvl(1, 1'b1, 12);
		wait_lvl(2, 1'b0, 40);
		// EEPROM step skipped; then each EEPROM source parks the core in hold.
		eeprom_done_i <= 1'b0;
		wr_ctl(sh | 32'h0000_0040);
		for (int s = 0; s < 3; s++)
		begin
			reg_write(OFF, sh | 32'h2);
			wait_lvl(1, 1'b1, 6);
			if (s == 0)
				stay(3, 1'b0, 40);
			else
			begin
				@(posedge clk_sys_i);
				{eeprom_set_hold_i, eeprom_err_i} <= 2'(s);
				@(posedge clk_sys_i);
				{eeprom_set_hold_i, eeprom_err_i} <= 2'b00;
				stay(2, 1'b1, 30);
				sh = sh | 32'h0000_0004;
				rd_ctl();
				wr_ctl(sh & ~32'h0000_0004);
				wait_lvl(2, 1'b0, 10);
			end
		end
		// Software fundamental reset with the halt strap high.
		reset_halt_pin_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		reg_write(OFF, sh | 32'h1);
		wait_lvl(0, 1'b1, 6);
		wait_lvl(0, 1'b0, 20);
		stay(2, 1'b1, 30);
		sh = 32'h0000_000C;
		rd_ctl();
		reset_halt_pin_i <= 1'b0;
		wr_ctl(32'h0000_0008);
		wait_lvl(2, 1'b0, 10);
		rd_ctl();
		give_verdict();
	end
endmodule // testbench
